// *** hw/ascc_clock_config.sv ***
`timescale 1ns/1ps
`include "ascc_defs.svh"

module ascc_clock_config
   import ascc_pkg::*;
(
   input  wire logic          core_clk,
   input  wire logic          rst_b,
   input  wire ascc_avs_req_t avsReq,
   output logic [31:0]        avsReadData,
   output logic               avsWaitRequest,
   input  wire logic          bclkIn,
   output logic               bclkOut,
   output logic               bclkOe,
   input  wire logic          fsyncIn,
   output logic               fsyncOut,
   output logic               fsyncOe,
   output ascc_clk_cfg_t      clkCfg,
   output logic               irq
);

   // ==================================================
   // decode helpers
   function automatic logic hit(input logic [7:0] addr,
                                input logic [5:0] idx);
      hit = (addr[1:0] == 2'h0) && (addr[7:2] == idx);
   endfunction

   // frame ratio for a code, zero when reserved
   function automatic logic [11:0] ratio_of(input logic [3:0] c);
      unique case (c)
         4'h0:    ratio_of = 12'h010;
         4'h1:    ratio_of = 12'h018;
         4'h2:    ratio_of = 12'h020;
         4'h3:    ratio_of = 12'h030;
         4'h4:    ratio_of = 12'h040;
         4'h5:    ratio_of = 12'h060;
         4'h6:    ratio_of = 12'h080;
         4'h7:    ratio_of = 12'h0c0;
         4'h8:    ratio_of = 12'h100;
         4'h9:    ratio_of = 12'h180;
         4'ha:    ratio_of = 12'h200;
         4'hb:    ratio_of = 12'h400;
         4'hc:    ratio_of = 12'h800;
         default: ratio_of = 12'h000;
      endcase
   endfunction

   // sample rate in hz for a code within a family
   function automatic int rate_hz(input logic [3:0] c,
                                  input logic fam);
      int base;
      base = 0;
      unique case (c)
         4'h0:    base = 8000;
         4'h1:    base = 16000;
         4'h2:    base = 24000;
         4'h3:    base = 32000;
         4'h4:    base = 48000;
         4'h5:    base = 96000;
         4'h6:    base = 192000;
         4'h7:    base = 384000;
         4'h8:    base = 768000;
         default: base = 0;
      endcase
      // the 44.1 kHz family is the 48 kHz one times 147/160
      rate_hz = fam ? (base / 160) * 147 : base;
   endfunction

   // frame period in core cycles to rate code
   function automatic logic [3:0] match_rate(input logic [11:0] p);
      int nom;
      int tol;
      match_rate = `ASCC_CODE_INVALID;
      for (int f = 0; f < 2; f++)
      begin
         for (int c = 0; c <= 8; c++)
         begin
            nom = `ASCC_CLK_HZ / rate_hz(4'(c), 1'(f));
            tol = nom / 32 + 1;
            if ((int'(p) >= nom - tol) && (int'(p) <= nom + tol))
            begin
               match_rate = 4'(c);
            end
         end
      end
   endfunction

   // edge count per frame to ratio code
   function automatic logic [3:0] match_ratio(input logic [11:0] n);
      match_ratio = `ASCC_CODE_INVALID;
      for (int c = 0; c <= 12; c++)
      begin
         if (n == ratio_of(4'(c)))
         begin
            match_ratio = 4'(c);
         end
      end
   endfunction

   localparam logic [11:0] TIMEOUT_CYC = 12'(`ASCC_TIMEOUT_CYC);
   localparam logic [7:0]  HALF_CYC    = 8'(`ASCC_BCLK_HALF_CYC);

   // ==================================================
   // registers and internal state
   logic [7:0]  roleCfg_reg;
   logic [7:0]  rateCfg_reg;
   logic [7:0]  srcCfg_reg;
   logic [3:0]  rateSts_reg;
   logic [3:0]  ratioSts_reg;
   logic [1:0]  intSts_reg;
   logic [1:0]  intMask_reg;
   logic        wrAcc;
   logic        master;
   logic        gated;
   logic [7:0]  halfCnt_reg;
   logic [11:0] bitCnt_reg;
   logic [11:0] genRatio;
   logic        lineBclk;
   logic        lineFsync;
   logic        bclkPrev_reg;
   logic        fsyncPrev_reg;
   logic        bclkRise;
   logic        fsyncRise;
   logic [11:0] periodCnt_reg;
   logic [11:0] edgeCnt_reg;
   logic [11:0] edgesNow;
   logic [3:0]  rateSts_next;
   logic [3:0]  ratioSts_next;
   logic [1:0]  intEvt;
   logic [1:0]  intSts_next;

   // write accepted at the edge that sees waitrequest low
   assign wrAcc  = avsReq.write && !avsWaitRequest
                   && avsReq.byteenable[0];
   assign master = roleCfg_reg[`ASCC_ROLE_BIT];
   assign gated  = master
                   && roleCfg_reg[`ASCC_GATE_BIT];

   // ==================================================
   // bus handshake: one wait state, then one ready cycle
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         avsWaitRequest <= 1'b1;
      end
      else if (!avsWaitRequest)
      begin
         avsWaitRequest <= 1'b1;
      end
      else if (avsReq.read || avsReq.write)
      begin
         avsWaitRequest <= 1'b0;
      end
   end

   // read data captured while the wait state is dropped
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         avsReadData <= 32'h0;
      end
      else if (avsReq.read && avsWaitRequest)
      begin
         avsReadData <= 32'h0;                  // unmapped reads zero
         if (hit(avsReq.address, `ASCC_IDX_ROLE))
            avsReadData[7:0] <= roleCfg_reg;
         if (hit(avsReq.address, `ASCC_IDX_RATE))
            avsReadData[7:0] <= rateCfg_reg;
         if (hit(avsReq.address, `ASCC_IDX_MON))
            avsReadData[7:0] <= {rateSts_reg, ratioSts_reg};
         if (hit(avsReq.address, `ASCC_IDX_SRC))
            avsReadData[7:0] <= {srcCfg_reg[7:3], 3'h0};
         if (hit(avsReq.address, `ASCC_IDX_INT_STS))
            avsReadData[1:0] <= intSts_reg;
         if (hit(avsReq.address, `ASCC_IDX_INT_MASK))
            avsReadData[1:0] <= intMask_reg;
      end
   end

   // ==================================================
   // configuration registers
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         roleCfg_reg <= `ASCC_ROLE_RST;
         rateCfg_reg <= `ASCC_RATE_RST;
         srcCfg_reg  <= `ASCC_SRC_RST;
         intMask_reg <= `ASCC_INT_RST;
      end
      else if (wrAcc)
      begin
         if (hit(avsReq.address, `ASCC_IDX_ROLE))
            roleCfg_reg <= avsReq.writedata[7:0];
         if (hit(avsReq.address, `ASCC_IDX_RATE))
            rateCfg_reg <= avsReq.writedata[7:0];
         if (hit(avsReq.address, `ASCC_IDX_SRC))
            srcCfg_reg <= {avsReq.writedata[7:3], 3'h0};
         if (hit(avsReq.address, `ASCC_IDX_INT_MASK))
            intMask_reg <= avsReq.writedata[1:0];
      end
   end

   // ==================================================
   // derived clock configuration
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         clkCfg <= '0;
      end
      else
      begin
         clkCfg.autoDerive <=
            !roleCfg_reg[`ASCC_CUSTOM_BIT];
         clkCfg.pllOn <= !roleCfg_reg[`ASCC_CUSTOM_BIT]
            && !roleCfg_reg[`ASCC_PLLOFF_BIT];
         clkCfg.rootFromRef <= !master
            && !roleCfg_reg[`ASCC_CUSTOM_BIT]
            && roleCfg_reg[`ASCC_PLLOFF_BIT]
            && srcCfg_reg[`ASCC_ROOT_BIT];
         clkCfg.refByRatio <= !roleCfg_reg[`ASCC_CUSTOM_BIT]
            && srcCfg_reg[`ASCC_SPEC_BIT];
         clkCfg.family <= master
            && roleCfg_reg[`ASCC_FAMILY_BIT];
         clkCfg.refFreqCode <=
            roleCfg_reg[`ASCC_FREQ_MSB:`ASCC_FREQ_LSB];
         clkCfg.refRatioCode <=
            srcCfg_reg[`ASCC_MRATIO_MSB:`ASCC_MRATIO_LSB];
         // slave auto mode follows the bus, not the codes
         if (!master && !roleCfg_reg[`ASCC_CUSTOM_BIT])
         begin
            clkCfg.rateCode   <= rateSts_reg;
            clkCfg.frameRatio <= ratioSts_reg;
         end
         else
         begin
            clkCfg.rateCode <=
               rateCfg_reg[`ASCC_PRATE_MSB:`ASCC_PRATE_LSB];
            clkCfg.frameRatio <=
               rateCfg_reg[`ASCC_PRATIO_MSB:`ASCC_PRATIO_LSB];
         end
      end
   end

   // ==================================================
   // master clock generation
   // a reserved ratio falls back to the reset ratio
   assign genRatio =
      (ratio_of(rateCfg_reg[`ASCC_PRATIO_MSB:`ASCC_PRATIO_LSB])
       == 12'h0)
      ? ratio_of(`ASCC_RATIO_DEFAULT)
      : ratio_of(rateCfg_reg[`ASCC_PRATIO_MSB:`ASCC_PRATIO_LSB]);

   // bit clock divider and frame position
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         halfCnt_reg <= 8'h0;
         bitCnt_reg  <= 12'h0;
         bclkOut     <= 1'b0;
         fsyncOut    <= 1'b0;
      end
      else if (!master || gated)
      begin
         halfCnt_reg <= 8'h0;
         bitCnt_reg  <= 12'h0;
         bclkOut     <= 1'b0;
         fsyncOut    <= 1'b0;
      end
      else if (halfCnt_reg == HALF_CYC - 8'h1)
      begin
         halfCnt_reg <= 8'h0;
         bclkOut     <= !bclkOut;
         // frame sync changes on the falling bit clock edge
         if (bclkOut)
         begin
            fsyncOut   <= (bitCnt_reg == 12'h0);
            bitCnt_reg <= (bitCnt_reg >= genRatio - 12'h1)
                          ? 12'h0 : bitCnt_reg + 12'h1;
         end
      end
      else
      begin
         halfCnt_reg <= halfCnt_reg + 8'h1;
      end
   end

   // pin drive follows the role
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bclkOe  <= 1'b0;
         fsyncOe <= 1'b0;
      end
      else
      begin
         bclkOe  <= master;
         fsyncOe <= master;
      end
   end

   // ==================================================
   // bus clock monitor
   assign lineBclk  = bclkOe ? bclkOut : bclkIn;
   assign lineFsync = fsyncOe ? fsyncOut : fsyncIn;
   assign bclkRise  = lineBclk && !bclkPrev_reg;
   assign fsyncRise = lineFsync && !fsyncPrev_reg;
   assign edgesNow  = (edgeCnt_reg == 12'hfff) ? edgeCnt_reg
                      : edgeCnt_reg + {11'h0, bclkRise};

   // line history for edge detection
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         bclkPrev_reg  <= 1'b0;
         fsyncPrev_reg <= 1'b0;
      end
      else
      begin
         bclkPrev_reg  <= lineBclk;
         fsyncPrev_reg <= lineFsync;
      end
   end

   // frame period and bit clock edge counters
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         periodCnt_reg <= TIMEOUT_CYC;
         edgeCnt_reg   <= 12'h0;
      end
      else if (fsyncRise)
      begin
         periodCnt_reg <= 12'h1;
         edgeCnt_reg   <= 12'h0;
      end
      else
      begin
         if (periodCnt_reg != TIMEOUT_CYC)
            periodCnt_reg <= periodCnt_reg + 12'h1;
         edgeCnt_reg <= edgesNow;
      end
   end

   // next status codes
   always_comb
   begin
      rateSts_next  = rateSts_reg;
      ratioSts_next = ratioSts_reg;
      if (fsyncRise && periodCnt_reg != TIMEOUT_CYC)
      begin
         rateSts_next  = match_rate(periodCnt_reg);
         ratioSts_next = match_ratio(edgesNow);
      end
      else if (fsyncRise || periodCnt_reg == TIMEOUT_CYC)
      begin
         rateSts_next  = `ASCC_CODE_INVALID;
         ratioSts_next = `ASCC_CODE_INVALID;
      end
   end

   // detected rate and ratio status
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rateSts_reg  <= `ASCC_CODE_INVALID;
         ratioSts_reg <= `ASCC_CODE_INVALID;
      end
      else
      begin
         rateSts_reg  <= rateSts_next;
         ratioSts_reg <= ratioSts_next;
      end
   end

   // ==================================================
   // interrupts: status change events, set wins over clear
   assign intEvt[`ASCC_INT_RATE_BIT]  = rateSts_next != rateSts_reg;
   assign intEvt[`ASCC_INT_RATIO_BIT] = ratioSts_next != ratioSts_reg;

   always_comb
   begin
      intSts_next = intSts_reg;
      if (wrAcc && hit(avsReq.address, `ASCC_IDX_INT_STS))
         intSts_next = intSts_next & ~avsReq.writedata[1:0];
      intSts_next = intSts_next | intEvt;
   end

   // sticky status and level interrupt
   always_ff @(posedge core_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         intSts_reg <= `ASCC_INT_RST;
         irq        <= 1'b0;
      end
      else
      begin
         intSts_reg <= intSts_next;
         irq        <= |(intSts_next & intMask_reg);
      end
   end

endmodule // ascc_clock_config

// *** shared/ascc_defs.svh ***
`ifndef ASCC_DEFS_SVH
`define ASCC_DEFS_SVH

// ==================================================
// clock and timing
`define ASCC_CLK_HZ          10000000
`define ASCC_TIMEOUT_US      200
`define ASCC_TIMEOUT_CYC     (`ASCC_TIMEOUT_US * (`ASCC_CLK_HZ / 1000000))
`define ASCC_BCLK_HALF_CYC   1

// ==================================================
// register indices (byte address is four times the index)
`define ASCC_IDX_ROLE        6'h13
`define ASCC_IDX_RATE        6'h14
`define ASCC_IDX_MON         6'h15
`define ASCC_IDX_SRC         6'h16
`define ASCC_IDX_INT_STS     6'h17
`define ASCC_IDX_INT_MASK    6'h18

// ==================================================
// reset values
`define ASCC_ROLE_RST        8'h02
`define ASCC_RATE_RST        8'h48
`define ASCC_MON_RST         8'hff
`define ASCC_SRC_RST         8'h10
`define ASCC_INT_RST         2'h0

// ==================================================
// field positions
`define ASCC_ROLE_BIT        7
`define ASCC_CUSTOM_BIT      6
`define ASCC_PLLOFF_BIT      5
`define ASCC_GATE_BIT        4
`define ASCC_FAMILY_BIT      3
`define ASCC_FREQ_MSB        2
`define ASCC_FREQ_LSB        0
`define ASCC_PRATE_MSB       7
`define ASCC_PRATE_LSB       4
`define ASCC_PRATIO_MSB      3
`define ASCC_PRATIO_LSB      0
`define ASCC_ROOT_BIT        7
`define ASCC_SPEC_BIT        6
`define ASCC_MRATIO_MSB      5
`define ASCC_MRATIO_LSB      3
`define ASCC_INT_RATE_BIT    0
`define ASCC_INT_RATIO_BIT   1

// ==================================================
// code limits
`define ASCC_RATE_MAX        4'h8
`define ASCC_RATIO_MAX       4'hc
`define ASCC_CODE_INVALID    4'hf
`define ASCC_RATIO_DEFAULT   4'h8

`endif

// *** shared/ascc_pkg.sv ***
package ascc_pkg;

   // ==================================================
   // derived clock configuration handed to the clock tree
   typedef struct packed {
      logic       autoDerive;
      logic       pllOn;
      logic       rootFromRef;
      logic       refByRatio;
      logic       family;
      logic [2:0] refFreqCode;
      logic [2:0] refRatioCode;
      logic [3:0] rateCode;
      logic [3:0] frameRatio;
   } ascc_clk_cfg_t;

   // ==================================================
   // avalon request bundle
   typedef struct packed {
      logic [7:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } ascc_avs_req_t;

endpackage

// *** tb/ascc_clock_config_props.sv ***
`timescale 1ns/1ps
// ==========
// port level checks of the clock configuration block
module ascc_clock_config_props
   import ascc_pkg::*;
(
   input wire logic          core_clk,
   input wire logic          rst_b,
   input wire ascc_avs_req_t avsReq,
   input wire logic [31:0]   avsReadData,
   input wire logic          avsWaitRequest,
   input wire logic          bclkIn,
   input wire logic          bclkOut,
   input wire logic          bclkOe,
   input wire logic          fsyncIn,
   input wire logic          fsyncOut,
   input wire logic          fsyncOe,
   input wire ascc_clk_cfg_t clkCfg,
   input wire logic          irq
);
   // one clock domain, all checks idle while in reset
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   // ==========
   // register bus
   wait_pulse_a: assert property ($fell(avsWaitRequest) |=> avsWaitRequest)
      else $error("waitrequest low for more than one cycle");
   bus_answer_a: assert property (
      (avsReq.read || avsReq.write) && avsWaitRequest |=> !avsWaitRequest)
      else $error("request not answered after one cycle");
   read_upper_a: assert property (
      !avsWaitRequest |-> avsReadData[31:8] == 24'h0)
      else $error("read data above bit 7 not zero");

   // ==========
   // serial clock outputs
   oe_pair_a: assert property (bclkOe == fsyncOe)
      else $error("bit clock and frame sync enables differ");
   out_oe_a: assert property (
      bclkOut || fsyncOut |-> bclkOe)
      else $error("clock output active while not driving");
   bclk_half_a: assert property ($rose(bclkOut) |=> $fell(bclkOut))
      else $error("bit clock high longer than one cycle");
   frame_sync_bit_a: assert property (
      $rose(fsyncOut) |-> fsyncOut [*2] ##1 !fsyncOut)
      else $error("frame sync not high for one bit period");

   // ==========
   // derived configuration
   rate_code_a: assert property (
      clkCfg.rateCode <= 4'h8 || clkCfg.rateCode == 4'hf)
      else $error("reserved rate code in configuration");
   ratio_code_a: assert property (
      clkCfg.frameRatio <= 4'hc || clkCfg.frameRatio == 4'hf)
      else $error("reserved frame ratio in configuration");
   custom_a: assert property (
      !clkCfg.autoDerive |-> !clkCfg.pllOn && !clkCfg.refByRatio)
      else $error("custom mode still derives settings");
   root_pll_a: assert property (
      clkCfg.rootFromRef |-> !clkCfg.pllOn)
      else $error("reference root chosen with pll running");

   // main scenarios reached
   cover property ($rose(bclkOe));
   cover property ($rose(irq));
   cover property (avsReq.write && !avsWaitRequest);
endmodule // ascc_clock_config_props

bind ascc_clock_config ascc_clock_config_props props_i (
   .core_clk(core_clk), .rst_b(rst_b), .avsReq(avsReq),
   .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
   .bclkIn(bclkIn), .bclkOut(bclkOut), .bclkOe(bclkOe),
   .fsyncIn(fsyncIn), .fsyncOut(fsyncOut), .fsyncOe(fsyncOe),
   .clkCfg(clkCfg), .irq(irq)
);

// *** tb/ascc_host_model.sv ***
`timescale 1ns/1ps
// ==========
// host that drives bit clock and frame sync in slave role
module ascc_host_model (
   input  wire logic core_clk,
   input  wire logic enable,
   input  var  int   halfCyc,
   input  var  int   frameBits,
   output logic      bclk,
   output logic      frame_sync
);
   int phaseCnt = 0;
   int bitCnt = 0;

   // start quiet
   initial
   begin
      bclk = 1'b0;
      frame_sync = 1'b0;
   end

   // host drives bit clock only while enabled in slave role; frame sync toggles every cycle when disabled
   always @(posedge core_clk)
   begin
      if (!enable)
      begin
         bclk <= 1'b0;        // clock stands still when not driving
         frame_sync <= ~frame_sync;     // frame sync toggles every core cycle when not driving
         phaseCnt <= 0;
         bitCnt <= 0;
      end
      else if (phaseCnt < halfCyc - 1)
         phaseCnt <= phaseCnt + 1;
      else
      begin
         phaseCnt <= 0;
         bclk <= ~bclk;
         // frame sync moves on the falling edge, high for the first bit
         if (bclk)
         begin
            bitCnt <= (bitCnt + 1) % frameBits;
            frame_sync <= ((bitCnt + 1) % frameBits) == 0;
         end
      end
   end
endmodule // ascc_host_model

// *** tb/testbench.sv ***
`timescale 1ns/1ps
// ==========
// self checking bench for the clock configuration block
module testbench
   import ascc_pkg::*;
;
   typedef struct {
      logic [7:0]    role, src;
      int            half, bits;
      logic [7:0]    mon;
      ascc_clk_cfg_t cfg;
   } ascc_row_t;

   logic          core_clk = 1'b0;
   logic          rst_b = 1'b0;
   ascc_avs_req_t avsReq = '0;
   logic [31:0]   avsReadData, rd;
   logic          avsWaitRequest, bclkOut, bclkOe, fsyncOut, fsyncOe, irq;
   logic          bclkIn, fsyncIn, hostBclk, hostFsync, pb, pf;
   logic          hostOn = 1'b0;
   logic [3:0]    laneEn = 4'hf;
   ascc_clk_cfg_t clkCfg;
   int            halfCyc = 1, frameBits = 16, n, k, cycleCnt = 0;
   int            numErrors = 0, checksDone = 0;
   ascc_row_t     rows [8];
   logic [7:0]    rAddr [6] = '{8'h4c, 8'h50, 8'h54, 8'h58, 8'h5c, 8'h60};
   logic [7:0]    rVal [6] = '{8'h02, 8'h48, 8'hff, 8'h10, 8'h00, 8'h00};

   // clock and pin levels shared by device and host
   always #50 core_clk = ~core_clk;
   assign bclkIn = bclkOe ? bclkOut : hostBclk;
   assign fsyncIn = fsyncOe ? fsyncOut : hostFsync;

   ascc_clock_config dut (
      .core_clk(core_clk), .rst_b(rst_b), .avsReq(avsReq),
      .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
      .bclkIn(bclkIn), .bclkOut(bclkOut), .bclkOe(bclkOe),
      .fsyncIn(fsyncIn), .fsyncOut(fsyncOut), .fsyncOe(fsyncOe),
      .clkCfg(clkCfg), .irq(irq)
   );

   ascc_host_model host (
      .core_clk(core_clk), .enable(hostOn), .halfCyc(halfCyc),
      .frameBits(frameBits), .bclk(hostBclk), .frame_sync(hostFsync)
   );

   // ==========
   // helpers
   task automatic wrap_up();
      $display("checks %0d errors %0d", checksDone, numErrors);
      if (numErrors == 0 && checksDone > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      checksDone++;
      if (seen !== exp)
      begin
         numErrors++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one bus access, held until waitrequest is sampled low
   task automatic bus(input logic [7:0] a, input logic w,
                      input logic [7:0] d);
      @(posedge core_clk);
      avsReq <= '{a, ~w, w, {24'h0, d}, laneEn};
      do
         @(posedge core_clk);
      while (avsWaitRequest !== 1'b0);
      rd = avsReadData;
      avsReq <= '0;
   endtask

   function automatic ascc_clk_cfg_t cf(logic [4:0] f, logic [2:0] q, r,
                                        logic [3:0] c, b);
      return {f, q, r, c, b};
   endfunction

   task automatic tick(input int c);
      repeat (c) @(posedge core_clk);
   endtask

   // hang guard
   always @(posedge core_clk)
   begin
      cycleCnt <= cycleCnt + 1;
      if (cycleCnt == 60000)
      begin
         numErrors++;
         wrap_up();
      end
   end

   // ==========
   // main sequence
   initial
   begin
      rows = '{
         '{8'h87, 8'h10, 0, 0, 8'hff, cf(5'h18, 3'd7, 3'd2, 4'd2, 4'd3)},
         '{8'ha8, 8'h78, 0, 0, 8'hff, cf(5'h13, 3'd0, 3'd7, 4'd2, 4'd3)},
         '{8'hc2, 8'h10, 0, 0, 8'hff, cf(5'h00, 3'd2, 3'd2, 4'd2, 4'd3)},
         '{8'h22, 8'h80, 0, 0, 8'hff, cf(5'h14, 3'd2, 3'd0, 4'hf, 4'hf)},
         '{8'h02, 8'h10, 39, 16, 8'h00, cf(5'h18, 3'd2, 3'd2, 4'd0, 4'd0)},
         '{8'h02, 8'h10, 13, 24, 8'h11, cf(5'h18, 3'd2, 3'd2, 4'd1, 4'd1)},
         '{8'h02, 8'h10, 10, 32, 8'h12, cf(5'h18, 3'd2, 3'd2, 4'd1, 4'd2)},
         '{8'h02, 8'h10, 7, 16, 8'h40, cf(5'h18, 3'd2, 3'd2, 4'd4, 4'd0)}};
      tick(10);
      rst_b <= 1'b1;
      bus(8'h50, 1'b1, 8'h23);
      foreach (rows[i])
      begin
         bus(8'h4c, 1'b1, rows[i].role);
         bus(8'h58, 1'b1, rows[i].src);
         halfCyc <= rows[i].half;
         frameBits <= rows[i].bits;
         hostOn <= (rows[i].half != 0);
         if (rows[i].half != 0)
         begin
            repeat (4) @(posedge fsyncIn);
            bus(8'h54, 1'b0, 8'h00);
            chk("monitor", rd, 32'(rows[i].mon));
         end
         tick(2);
         chk("clkCfg", 32'(clkCfg), 32'(rows[i].cfg));
      end
      // interrupt: raised, masked, cleared, raised by invalid codes from the toggling frame sync
      chk("irqMasked", {31'h0, irq}, 32'd0);
      bus(8'h5c, 1'b0, 8'h00);
      chk("intStatus", rd, 32'h3);
      bus(8'h60, 1'b1, 8'h03);
      tick(2);
      chk("irqOn", {31'h0, irq}, 32'd1);
      bus(8'h5c, 1'b1, 8'h03);
      tick(2);
      chk("irqCleared", {31'h0, irq}, 32'd0);
      hostOn <= 1'b0;
      tick(2100);
      bus(8'h54, 1'b0, 8'h00);
      chk("monitorLost", rd, 32'hff);
      chk("irqLost", {31'h0, irq}, 32'd1);
      // master role: 256 bit clocks per frame, then gated
      bus(8'h50, 1'b1, 8'h48);
      bus(8'h4c, 1'b1, 8'h80);
      n = 0;
      k = 0;
      pb = 1'b1;
      pf = 1'b1;
      repeat (1200)
      begin
         @(posedge core_clk);
         if (bclkOut && !pb && k == 1)
            n++;
         if (fsyncOut && !pf)
            k++;
         pb = bclkOut;
         pf = fsyncOut;
      end
      chk("bitsPerFrame", 32'(n), 32'd256);
      bus(8'h4c, 1'b1, 8'h90);
      tick(2);
      n = 0;
      repeat (40)
      begin
         @(posedge core_clk);
         n += int'(bclkOut | fsyncOut);
      end
      chk("gatedEdges", 32'(n), 32'd0);
      chk("gatedOe", {31'h0, bclkOe}, 32'd1);
      // gated frame sync never rises, so the monitor must time out
      tick(2000);
      bus(8'h54, 1'b0, 8'h00);
      chk("monitorTimeout", rd, 32'hff);
      bus(8'h4c, 1'b1, 8'h10);
      tick(2);
      chk("slaveOe", {31'h0, bclkOe}, 32'd0);
      // reset in mid run, then reset values
      rst_b <= 1'b0;
      tick(10);
      rst_b <= 1'b1;
      foreach (rAddr[i])
      begin
         bus(rAddr[i], 1'b0, 8'h00);
         chk("resetValue", rd, 32'(rVal[i]));
      end
      // read-only, unmapped, lane-off and reserved-bit writes
      bus(8'h54, 1'b1, 8'h00);
      bus(8'h54, 1'b0, 8'h00);
      chk("monitorRo", rd, 32'hff);
      bus(8'h7c, 1'b1, 8'h5a);
      bus(8'h7c, 1'b0, 8'h00);
      chk("unmapped", rd, 32'h0);
      laneEn <= 4'h0;
      bus(8'h50, 1'b1, 8'h11);
      laneEn <= 4'hf;
      bus(8'h50, 1'b0, 8'h00);
      chk("laneOff", rd, 32'h48);
      bus(8'h58, 1'b1, 8'hff);
      bus(8'h58, 1'b0, 8'h00);
      chk("srcReserved", rd, 32'hf8);
      wrap_up();
   end
endmodule // testbench
